// file: link_model.sv
// link model issuing register reads and writes
`timescale 1ns/1ps
`default_nettype none
module link_model (
  input  wire logic       clock,
  input  wire logic [7:0] reg_rdata,
  output var  logic       reg_write = 0, reg_read = 0,
  output var  logic [5:0] reg_addr = 0,
  output var  logic [7:0] reg_wdata = 0);
  task acc(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clock);
    {reg_write, reg_read, reg_addr, reg_wdata} <= {w, !w, a, d};
    @(posedge clock);
    // released data is inverted so a stale byte never looks valid
    {reg_write, reg_read, reg_wdata} <= {2'b00, ~d};
    // read data stands from the strobe edge; take it at the edge where valid is seen
    @(posedge clock);
    q = reg_rdata;
  endtask
endmodule // link_model
`default_nettype wire

// file: otg_ctrl_alias_and_rise_irq_enable.v
// on-the-go control aliases and rising-edge event enables
`timescale 1ns/1ps
`default_nettype none
`include "otg_rise_regs.vh"
// Summary of operation
// [RQ1] set alias ors written ones, reads control
// [RQ2] clear alias clears written ones, reads control
// [RQ3] enabled rising transitions raise event pulses
// [RQ4] enable bits reset to all ones
// [RQ5] ident rise masked without pullup, 50ms after
// [RQ6] bit 4 gates ident grounded rise
// [RQ7] bit 3 gates session ended rise
// [RQ8] bit 2 gates session ok rise
// [RQ9] bit 1 gates bus power ok rise
// [RQ10] bit 0 detach rise only in host mode
// [RQ11] enable bits 7..5 read zero
// [RQ12] control resets to 0x06
// [RQ13] pump pin needs drive and pump select
// [RQ14] link checks discharge before charging
// [RQ15] link clears discharge after session ended
// [RQ16] pullup bit enables ident line sampling
module otg_ctrl_alias_and_rise_irq_enable (
  // clock and reset
  input  wire       clock,
  input  wire       reset,
  // register access from the link
  input  wire [5:0] reg_addr,
  input  wire       reg_write,
  input  wire       reg_read,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  output reg        reg_rvalid,
  // transceiver indications, asynchronous
  input  wire       ident_grounded,
  input  wire       session_ended,
  input  wire       a_device_session_ok,
  input  wire       bus_power_ok,
  input  wire       far_end_detach,
  // control outputs
  output reg  [7:0] otg_control,
  output reg        supply_pump_enable_pin,
  output reg        ident_sample_enable,
  // event notification
  output reg  [4:0] rise_event
);
  reg  [7:0]                 ctl_q;
  reg  [7:0]                 ctl_d;
  reg  [`RISE_WIDTH-1:0]     en_q;
  reg  [`RISE_WIDTH-1:0]     en_d;
  reg  [`SETTLE_W-1:0]       settle_q;
  reg                        settled_q;
  wire [4:0]                 rise;
  wire                       host_mode;
  wire [4:0]                 qualify;

  // session ok is the a-device session valid level itself
  rise_detect u_rise (
    .clock    (clock),
    .reset    (reset),
    .level_in ({ident_grounded, session_ended, a_device_session_ok, // RQ8
                bus_power_ok, far_end_detach}),
    .rise     (rise)
  );

  always @* begin
    ctl_d = ctl_q;
    en_d  = en_q;
    if (reg_write) begin
      case (reg_addr)
        `OFS_OTG_SET: ctl_d = ctl_q | reg_wdata; // RQ1
        `OFS_OTG_CLR: ctl_d = ctl_q & ~reg_wdata; // RQ2
        `OFS_RISE_EN: en_d  = reg_wdata[`RISE_WIDTH-1:0]; // RQ11
        default:      ctl_d = ctl_q;
      endcase
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      ctl_q <= `CTL_RESET; // RQ12
      en_q  <= `RISE_RESET; // RQ4
    end else begin
      ctl_q <= ctl_d;
      en_q  <= en_d;
    end
  end

  // settle timer restarts whenever pullup is off, so the mask covers the id line charging
  always @(posedge clock) begin
    if (reset || !ctl_q[`CTL_IDPU_BIT]) begin
      settle_q  <= {`SETTLE_W{1'b0}};
      settled_q <= 1'b0; // RQ5
    end else if (!settled_q) begin
      if (settle_q == `ID_SETTLE_CYC - 1)
        settled_q <= 1'b1; // RQ5
      else
        settle_q <= settle_q + 1'b1;
    end
  end

  assign host_mode = ctl_q[`CTL_PLUS_PD_BIT] & ctl_q[`CTL_MINUS_PD_BIT];
  assign qualify   = {settled_q, 1'b1, 1'b1, 1'b1, host_mode}; // RQ10

  always @(posedge clock) begin
    if (reset) begin
      rise_event             <= 5'h00;
      reg_rdata              <= 8'h00;
      reg_rvalid             <= 1'b0;
      otg_control            <= `CTL_RESET;
      supply_pump_enable_pin <= 1'b0;
      ident_sample_enable    <= 1'b0;
    end else begin
      // bits 4..0 map ident, session ended, session ok, bus power, detach
      rise_event <= rise & en_q & qualify; // RQ3 RQ6 RQ7 RQ9
      reg_rvalid <= reg_read;
      case (reg_addr)
        `OFS_OTG_SET: reg_rdata <= ctl_q; // RQ1
        `OFS_OTG_CLR: reg_rdata <= ctl_q; // RQ2
        `OFS_RISE_EN: reg_rdata <= {3'h0, en_q}; // RQ11
        default:      reg_rdata <= 8'h00;
      endcase
      otg_control            <= ctl_d;
      supply_pump_enable_pin <= ctl_d[`CTL_DRIVE_BIT] & ctl_d[`CTL_PUMPSEL_BIT]; // RQ13
      ident_sample_enable    <= ctl_d[`CTL_IDPU_BIT]; // RQ16
    end
  end
endmodule // otg_ctrl_alias_and_rise_irq_enable
`default_nettype wire

// file: otg_ctrl_alias_and_rise_irq_enable_tb_top.sv
// bench for the control aliases and rising events
`timescale 1ns/1ps
`default_nettype none
module otg_ctrl_alias_and_rise_irq_enable_tb_top;
  logic       clock = 0, reset = 1, reg_write, reg_read, reg_rvalid;
  logic       supply_pump_enable_pin, ident_sample_enable;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, otg_control, c = 8'h06, d, q;
  logic [4:0] ind = 0, rise_event, e = 5'h1f, s;
  logic [1:0] a;
  int         n_mismatch = 0, checks_done = 0, seed = 32'ha1641f5a;
  always #50 clock = ~clock;
  link_model i_link_model (.*);
  otg_ctrl_alias_and_rise_irq_enable i_otg_ctrl_alias_and_rise_irq_enable (.*,
    .ident_grounded(ind[4]), .session_ended(ind[3]), .a_device_session_ok(ind[2]),
    .bus_power_ok(ind[1]), .far_end_detach(ind[0]));
  task chk(input string n, input logic [7:0] x, y);
    checks_done++;
    if (y !== x) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", n, x, y);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clock);
    reset <= 0;
    for (int i = 0; i < 60; i++) begin
      a = i < 3 ? 2'(i) : 2'($random(seed));
      i_link_model.acc(0, 6'h0b + a, 8'h00, q);
      chk("read", a == 2 ? {3'h0, e} : a == 3 ? 8'h00 : c, q);
      d = $random(seed);
      // charging needs a checked discharge first, which this link cannot see
      if (a == 0) d[4] = 1'b0;
      i_link_model.acc(1, 6'h0b + a, d, q);
      if (a == 0) c = c | d;
      if (a == 1) c = c & ~d;
      if (a == 2) e = d[4:0];
      chk("pump", {7'h0, c[6] & c[5]}, {7'h0, supply_pump_enable_pin});
      chk("sample", {7'h0, c[0]}, {7'h0, ident_sample_enable});
      s = 0;
      @(posedge clock) ind <= 5'h1f;
      repeat (8) @(posedge clock) s = s | rise_event;
      ind <= 5'h00;
      repeat (6) @(posedge clock);
      // ident rise stays masked: its 50 ms settle outlasts the run
      chk("event", {4'h0, e[3:1], e[0] & c[2] & c[1]}, {3'h0, s});
      // session ended has risen above, so a running discharge is stopped now
      if (c[3]) begin
        i_link_model.acc(1, 6'h0c, 8'h08, q);
        c[3] = 1'b0;
      end
    end
    conclude;
  end
  initial begin
    #8000000;
    n_mismatch++;
    conclude;
  end
endmodule // otg_ctrl_alias_and_rise_irq_enable_tb_top
`default_nettype wire

// file: otg_rise_chk.sv
// assertions for the control aliases and rising events
`timescale 1ns/1ps
`default_nettype none
module otg_rise_chk (
  input wire logic       clock, reset, reg_write, reg_read, reg_rvalid,
  input wire logic       supply_pump_enable_pin,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata, reg_rdata, otg_control,
  input wire logic [4:0] rise_event);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  AST_SET: assert property (reg_write && reg_addr == 6'h0b |=>
    &(otg_control | ~$past(reg_wdata))) else $error("set");
  AST_CLR: assert property (reg_write && reg_addr == 6'h0c |=>
    !(otg_control & $past(reg_wdata))) else $error("clr");
  AST_KEEP: assert property (!reg_write |=> $stable(otg_control)) else $error("keep");
  AST_RD: assert property (reg_read && reg_addr inside {6'h0b, 6'h0c} |=>
    reg_rdata == $past(otg_control)) else $error("rd");
  AST_RSV: assert property (reg_read && reg_addr == 6'h0d |=>
    !reg_rdata[7:5]) else $error("rsv");
  AST_VLD: assert property (reg_rvalid == $past(reg_read)) else $error("vld");
  AST_PUMP: assert property (supply_pump_enable_pin == &otg_control[6:5]) else $error("pump");
  AST_ID: assert property (rise_event[4] |-> $past(otg_control[0])) else $error("id");
endmodule // otg_rise_chk
bind otg_ctrl_alias_and_rise_irq_enable otg_rise_chk i_otg_rise_chk (.*);
`default_nettype wire

// file: otg_rise_regs.vh
// register offsets, field positions, reset values and timing counts
`ifndef OTG_RISE_REGS_VH
`define OTG_RISE_REGS_VH
`define OFS_OTG_SET      6'h0b
`define OFS_OTG_CLR      6'h0c
`define OFS_RISE_EN      6'h0d
`define CTL_IDPU_BIT     0
`define CTL_PLUS_PD_BIT  1
`define CTL_MINUS_PD_BIT 2
`define CTL_DRIVE_BIT    5
`define CTL_PUMPSEL_BIT  6
`define CTL_RESET        8'h06
`define RISE_RESET       5'h1f
`define RISE_WIDTH       5
`define CLOCK_HZ         10000000
`define ID_SETTLE_MS     50
`define ID_SETTLE_CYC    (`CLOCK_HZ / 1000 * `ID_SETTLE_MS)
`define SETTLE_W         22
`endif

// file: rise_detect.v
// per-signal synchroniser and rising-edge detector
`timescale 1ns/1ps
`default_nettype none
module rise_detect (
  // clock and reset
  input  wire       clock,
  input  wire       reset,
  // raw level and rising pulse
  input  wire [4:0] level_in,
  output wire [4:0] rise
);
  reg [4:0] meta_q;
  reg [4:0] sync_q;
  reg [4:0] prev_q;
  genvar i;
  generate
    for (i = 0; i < 5; i = i + 1) begin : g_bit
      always @(posedge clock) begin
        if (reset) begin
          meta_q[i] <= 1'b0;
          sync_q[i] <= 1'b0;
          prev_q[i] <= 1'b0;
        end else begin
          meta_q[i] <= level_in[i];
          sync_q[i] <= meta_q[i];
          prev_q[i] <= sync_q[i];
        end
      end
      assign rise[i] = sync_q[i] & ~prev_q[i];
    end
  endgenerate
endmodule // rise_detect
`default_nettype wire
